// ---- hdl/eeprom_wr_pkg.sv ----
package eeprom_wr_pkg;

	// ==========================================================
	// Clock and write cycle timing
	localparam int CLK_PERIOD_NS = 4;                   // 250 MHz system clock
	localparam int WRITE_TIME_US = 4000;                // Longest internal write cycle
	localparam int WRITE_CYCLES  = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int WCNT_W        = 24;                  // Width of write cycle counter

	// ==========================================================
	// Select code layout
	localparam logic [3:0] SEL_MEMORY  = 4'ha;          // Device type for memory array
	localparam logic [3:0] SEL_FEATURE = 4'hb;          // Device type for feature spaces
	localparam int         SEL_DIR_BIT = 0;             // Direction bit, one reads
	localparam int         SEL_CE_LSB  = 1;             // Chip enable bits in select byte
	localparam int         SEL_CE_MSB  = 3;
	localparam int         SEL_TYPE_LSB = 4;            // Device type nibble
	localparam int         SEL_TYPE_MSB = 7;

	// ==========================================================
	// Configuration register fields
	localparam int CFG_CE_LSB     = 1;                  // Chip enable bits of address config
	localparam int CFG_CE_MSB     = 3;
	localparam int PROT_ACT_BIT   = 3;                  // Protect activate bit
	localparam int PROT_SIZE_LSB  = 1;                  // Protect size bits
	localparam int PROT_SIZE_MSB  = 2;

	// ==========================================================
	// Feature space codes from first address byte bits 7 to 5
	localparam logic [2:0] FEAT_TYPEID  = 3'h7;
	localparam logic [2:0] FEAT_ADDRCFG = 3'h6;
	localparam logic [2:0] FEAT_PROTCFG = 3'h5;
	localparam logic [2:0] FEAT_IDPAGE  = 3'h0;
	localparam logic [2:0] FEAT_LOCK    = 3'h3;

	// ==========================================================
	// Page and byte geometry
	localparam int         PAGE_OFS_W = 7;              // 128 byte page offset
	localparam logic [2:0] BIT_LAST   = 3'h7;           // Eighth bit of a byte
	localparam logic [2:0] BIT_STOP   = 3'h1;           // Count once the tenth slot's clock has risen
	localparam int         FIFO_DEPTH = 16;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		TGT_MEMORY, TGT_TYPEID, TGT_ADDRCFG, TGT_PROTCFG, TGT_IDPAGE, TGT_LOCK, TGT_NONE
	} target_e;

	typedef struct packed {
		target_e     target;                            // Space the byte is written to
		logic [15:0] addr;                              // Byte address in that space
		logic [7:0]  data;                              // Data byte
	} wr_item_s;

	localparam int ITEM_W = $bits(wr_item_s);

	typedef enum {
		ST_IDLE, ST_SELECT, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_IGNORE, ST_BUSY
	} link_state_e;

endpackage

// ---- hdl/eeprom_write_slave.sv ----
// Operation
// - Slave only, master owns the clock
// - Start is SDA fall with SCL high
// - Watch for start except while writing
// - Stop ends the current communication
// - Stop after read no_acknowledge gives standby
// - Sample SDA on rising SCL edge
// - Release after eight bits, ack ninth
// - Ack select only when chip enable matches
// - Mismatch: no ack, drop to standby
// - Select bit zero gives direction
// - Type nibble picks memory or features
// - First address byte: high bits, feature
// - Second address byte: low bits, offset
// - Bytes travel most significant bit first
// - Select, two addresses, then data, acked
// - Only stop in tenth slot writes
// - After write, counter past last byte
// - Busy writing: SDA released, no answers
// - Protected bytes get no ack, unchanged
// - Byte write: one byte then stop
// - Page write wraps within 128 bytes
// - Advance page counter after each accepted byte
// - Chip enable bits from config bits 3..1
// - Activate bit enables quarter-based protection
`timescale 1ns/1ns
module eeprom_write_slave #(
	parameter int WRITE_CYCLES = eeprom_wr_pkg::WRITE_CYCLES
) (
	// System
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Two-wire bus pins
	input  wire logic                          sclPin,
	input  wire logic                          sdaIn,
	output logic                               sdaOut,
	output logic                               sdaOe,
	input  wire logic                          writeInhibitPin,
	// Configuration from the register store
	input  wire logic [7:0]                    addressConfig,
	input  wire logic [7:0]                    protectionConfig,
	// Staged write bytes towards the array
	output logic                               stageValid,
	output eeprom_wr_pkg::wr_item_s            stageItem,
	input  wire logic                          stageReady,
	// Write cycle control and status
	output logic                               commitWrite,
	output logic                               discardWrite,
	output logic                               writeBusy,
	output logic [15:0]                        addrCounter
);

	// ==========================================================
	// Synchronised pins
	logic scl;                                          // SCL level
	logic sda;                                          // SDA level
	logic wi;                                           // Write inhibit level
	logic sclRise;
	logic sclFall;
	logic sdaRise;
	logic sdaFall;
	logic startSeen;                                    // Start condition this cycle
	logic stopSeen;                                     // Stop condition this cycle

	pin_sync u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.sclPin  (sclPin),
		.sdaPin  (sdaIn),
		.wiPin   (writeInhibitPin),
		.scl     (scl),
		.sda     (sda),
		.wi      (wi),
		.sclRise (sclRise),
		.sclFall (sclFall),
		.sdaRise (sdaRise),
		.sdaFall (sdaFall)
	);

	assign startSeen = sdaFall & scl;
	assign stopSeen  = sdaRise & scl;

	// ==========================================================
	// Protocol state
	eeprom_wr_pkg::link_state_e state;                  // Transfer phase
	logic [2:0]                 bitCnt;                 // Bits received of current byte
	logic [7:0]                 shift;                  // Shift register
	logic                       byteReady;              // Eight bits in, ack pending
	logic                       ackSlot;                // Ninth clock in progress
	logic                       ackNow;                 // Decision for this ack slot
	logic                       gotData;                // A data byte closed the last slot
	logic                       isRead;                 // Direction of this transfer
	logic                       featSel;                // Feature device type selected
	eeprom_wr_pkg::target_e     target;                 // Decoded target space
	logic [15:0]                addr;                   // Current write address
	logic [15:0]                lastAddr;               // Last byte accepted
	logic [eeprom_wr_pkg::WCNT_W-1:0] waitCnt;          // Write cycle countdown
	logic [7:0]                 byteIn;                 // Completed byte incl. last bit
	logic                       fifoReady;              // Room in the staging buffer
	logic                       push;                   // Accept a data byte
	eeprom_wr_pkg::wr_item_s    pushItem;
	logic                       commitNow;              // Stop in the tenth slot after a data ack

	assign byteIn = {shift[6:0], sda};

	// ==========================================================
	// Write protection decision for one byte
	function automatic logic isProtected(input eeprom_wr_pkg::target_e tgt,
	                                      input logic [15:0] a, input logic inh);
		logic [1:0] size;
		logic       hit;
		size = protectionConfig[eeprom_wr_pkg::PROT_SIZE_MSB:eeprom_wr_pkg::PROT_SIZE_LSB];
		case (size)
			2'h0: hit = a[15] & a[14];                  // Upper quarter
			2'h1: hit = a[15];                          // Upper half
			2'h2: hit = a[15] | a[14];                  // Upper three quarters
			default: hit = 1'b1;                        // Whole array
		endcase
		if (inh || tgt == eeprom_wr_pkg::TGT_TYPEID || tgt == eeprom_wr_pkg::TGT_NONE) begin
			isProtected = 1'b1;
		end else if (tgt == eeprom_wr_pkg::TGT_MEMORY) begin
			isProtected = protectionConfig[eeprom_wr_pkg::PROT_ACT_BIT] & hit;
		end else begin
			isProtected = 1'b0;
		end
	endfunction

	// ==========================================================
	// Next address inside the page, upper bits held
	function automatic logic [15:0] pageNext(input logic [15:0] a);
		pageNext = {a[15:eeprom_wr_pkg::PAGE_OFS_W],
		            a[eeprom_wr_pkg::PAGE_OFS_W-1:0] + 1'b1};
	endfunction

	// ==========================================================
	// Feature code to target space
	function automatic eeprom_wr_pkg::target_e featTarget(input logic [2:0] code);
		case (code)
			eeprom_wr_pkg::FEAT_TYPEID:  featTarget = eeprom_wr_pkg::TGT_TYPEID;
			eeprom_wr_pkg::FEAT_ADDRCFG: featTarget = eeprom_wr_pkg::TGT_ADDRCFG;
			eeprom_wr_pkg::FEAT_PROTCFG: featTarget = eeprom_wr_pkg::TGT_PROTCFG;
			eeprom_wr_pkg::FEAT_IDPAGE:  featTarget = eeprom_wr_pkg::TGT_IDPAGE;
			eeprom_wr_pkg::FEAT_LOCK:    featTarget = eeprom_wr_pkg::TGT_LOCK;
			default:                     featTarget = eeprom_wr_pkg::TGT_NONE;
		endcase
	endfunction

	// Data byte accepted when unprotected and buffer has room
	assign push = sclRise & ~ackSlot & (bitCnt == eeprom_wr_pkg::BIT_LAST)
	            & (state == eeprom_wr_pkg::ST_DATA) & ~isProtected(target, addr, wi) & fifoReady;
	assign pushItem = '{target: target, addr: addr, data: byteIn};
	// The stop's own clock rise is counted, so the tenth slot shows one bit in
	assign commitNow = stopSeen && state == eeprom_wr_pkg::ST_DATA && gotData
	                 && bitCnt == eeprom_wr_pkg::BIT_STOP;

	// ==========================================================
	// Bit counter and shift register, sampled on rising SCL
	always_ff @(posedge clk) begin
		if (!rst_n || startSeen || stopSeen) begin
			bitCnt    <= '0;
			byteReady <= 1'b0;
		end else if (sclRise && !ackSlot) begin
			shift     <= byteIn;
			bitCnt    <= bitCnt + 1'b1;
			byteReady <= bitCnt == eeprom_wr_pkg::BIT_LAST;
		end else if (sclFall && byteReady) begin
			byteReady <= 1'b0;
		end
	end

	// ==========================================================
	// Acknowledge slot: drive low across the ninth clock
	always_ff @(posedge clk) begin
		if (!rst_n || stopSeen || startSeen || state == eeprom_wr_pkg::ST_BUSY) begin
			sdaOe   <= 1'b0;
			ackSlot <= 1'b0;
		end else if (sclFall && byteReady) begin
			sdaOe   <= ackNow;
			ackSlot <= 1'b1;
		end else if (sclFall && ackSlot) begin
			sdaOe   <= 1'b0;
			ackSlot <= 1'b0;
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge clk) begin
		sdaOut <= 1'b0;
	end

	// ==========================================================
	// Transfer sequencing, one step per completed byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state   <= eeprom_wr_pkg::ST_IDLE;
			ackNow  <= 1'b0;
			gotData <= 1'b0;
			isRead  <= 1'b0;
			featSel <= 1'b0;
			target  <= eeprom_wr_pkg::TGT_NONE;
			addr    <= '0;
		end else if (state == eeprom_wr_pkg::ST_BUSY) begin
			if (waitCnt == '0) begin
				state <= eeprom_wr_pkg::ST_IDLE;
			end
		end else if (startSeen) begin
			state   <= eeprom_wr_pkg::ST_SELECT;
			gotData <= 1'b0;
		end else if (stopSeen) begin
			// Stop right after a data ack slot starts the write cycle
			if (commitNow) begin
				state <= eeprom_wr_pkg::ST_BUSY;
			end else begin
				state <= eeprom_wr_pkg::ST_IDLE;
			end
		end else if (sclFall && ackSlot) begin
			gotData <= gotData && ackNow;               // Only an acked data byte keeps it
		end else if (sclRise && !ackSlot && bitCnt == eeprom_wr_pkg::BIT_LAST) begin
			gotData <= 1'b0;
			case (state)
				eeprom_wr_pkg::ST_SELECT: begin
					isRead  <= byteIn[eeprom_wr_pkg::SEL_DIR_BIT];
					featSel <= byteIn[eeprom_wr_pkg::SEL_TYPE_MSB:eeprom_wr_pkg::SEL_TYPE_LSB]
					           == eeprom_wr_pkg::SEL_FEATURE;
					if (byteIn[eeprom_wr_pkg::SEL_CE_MSB:eeprom_wr_pkg::SEL_CE_LSB]
					    == addressConfig[eeprom_wr_pkg::CFG_CE_MSB:eeprom_wr_pkg::CFG_CE_LSB]
					    && (byteIn[eeprom_wr_pkg::SEL_TYPE_MSB:eeprom_wr_pkg::SEL_TYPE_LSB]
					        == eeprom_wr_pkg::SEL_MEMORY
					     || byteIn[eeprom_wr_pkg::SEL_TYPE_MSB:eeprom_wr_pkg::SEL_TYPE_LSB]
					        == eeprom_wr_pkg::SEL_FEATURE)) begin
						ackNow <= 1'b1;
						// Read data path lives elsewhere; wait for stop
						state  <= byteIn[eeprom_wr_pkg::SEL_DIR_BIT] ? eeprom_wr_pkg::ST_IGNORE
						                                            : eeprom_wr_pkg::ST_ADDR_HI;
					end else begin
						ackNow <= 1'b0;
						state  <= eeprom_wr_pkg::ST_IGNORE;
					end
				end
				eeprom_wr_pkg::ST_ADDR_HI: begin
					ackNow     <= 1'b1;
					addr[15:8] <= byteIn;
					target     <= featSel ? featTarget(byteIn[7:5]) : eeprom_wr_pkg::TGT_MEMORY;
					state      <= eeprom_wr_pkg::ST_ADDR_LO;
				end
				eeprom_wr_pkg::ST_ADDR_LO: begin
					ackNow    <= 1'b1;
					addr[7:0] <= (target == eeprom_wr_pkg::TGT_IDPAGE) ? {1'b0, byteIn[6:0]}
					           : byteIn;
					state     <= eeprom_wr_pkg::ST_DATA;
				end
				eeprom_wr_pkg::ST_DATA: begin
					ackNow <= push;
					gotData <= push;                        // Data byte taken, stop may commit
					if (push) begin
						addr <= pageNext(addr);
					end
				end
				default: begin
					ackNow <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Last accepted byte, used to place the counter after a write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lastAddr <= '0;
		end else if (push) begin
			lastAddr <= addr;
		end
	end

	// ==========================================================
	// Internal write cycle timer and address counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitCnt     <= '0;
			writeBusy   <= 1'b0;
			addrCounter <= '0;
		end else if (state != eeprom_wr_pkg::ST_BUSY) begin
			waitCnt   <= eeprom_wr_pkg::WCNT_W'(WRITE_CYCLES - 1);
			writeBusy <= 1'b0;
		end else if (waitCnt == '0) begin
			writeBusy   <= 1'b0;
			addrCounter <= pageNext(lastAddr);
		end else begin
			waitCnt   <= waitCnt - 1'b1;
			writeBusy <= 1'b1;
		end
	end

	// ==========================================================
	// Commit on a tenth-slot stop, discard on other starts and stops outside the write cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			commitWrite  <= 1'b0;
			discardWrite <= 1'b0;
		end else begin
			commitWrite  <= commitNow;
			discardWrite <= (stopSeen || startSeen) && state != eeprom_wr_pkg::ST_BUSY && !commitNow;
		end
	end

	// ==========================================================
	// Staging buffer towards the array
	wr_fifo #(
		.WIDTH (eeprom_wr_pkg::ITEM_W),
		.DEPTH (eeprom_wr_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (push),
		.inData   (pushItem),
		.inReady  (fifoReady),
		.outValid (stageValid),
		.outData  (stageItem),
		.outReady (stageReady)
	);

	// ==========================================================
	// Checks
	chk_busy_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		state == eeprom_wr_pkg::ST_BUSY |=> !sdaOe)
		else $error("SDA driven during write cycle");
	chk_start_select: assert property (@(posedge clk) disable iff (!rst_n)
		startSeen && state != eeprom_wr_pkg::ST_BUSY |=> state == eeprom_wr_pkg::ST_SELECT)
		else $error("Start not taken");
	chk_busy_deaf: assert property (@(posedge clk) disable iff (!rst_n)
		state == eeprom_wr_pkg::ST_BUSY && waitCnt != '0 |=> state == eeprom_wr_pkg::ST_BUSY)
		else $error("Left write cycle early");
	chk_stop_idle: assert property (@(posedge clk) disable iff (!rst_n)
		stopSeen && state == eeprom_wr_pkg::ST_IGNORE |=> state == eeprom_wr_pkg::ST_IDLE)
		else $error("Stop did not end transfer");
	chk_ack_release: assert property (@(posedge clk) disable iff (!rst_n)
		sclFall && ackSlot && !startSeen && !stopSeen |=> !sdaOe && !ackSlot)
		else $error("Ack not released after ninth clock");
	chk_nomatch_ignore: assert property (@(posedge clk) disable iff (!rst_n)
		sclRise && !ackSlot && bitCnt == eeprom_wr_pkg::BIT_LAST && state == eeprom_wr_pkg::ST_SELECT
		&& byteIn[3:1] != addressConfig[3:1] && !startSeen && !stopSeen
		|=> state == eeprom_wr_pkg::ST_IGNORE && !ackNow)
		else $error("Mismatched select answered");
	chk_inhibit_block: assert property (@(posedge clk) disable iff (!rst_n)
		wi |-> !push)
		else $error("Byte accepted while inhibited");
	chk_commit_busy: assert property (@(posedge clk) disable iff (!rst_n)
		commitWrite |-> state == eeprom_wr_pkg::ST_BUSY ##1 writeBusy)
		else $error("Commit without write cycle");
	chk_page_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		push && !startSeen && !stopSeen |=> addr[15:7] == $past(addr[15:7])
		&& addr[6:0] == $past(addr[6:0]) + 7'h1)
		else $error("Page counter wrong");
	chk_after_write: assert property (@(posedge clk) disable iff (!rst_n)
		state == eeprom_wr_pkg::ST_BUSY && waitCnt == '0 |=> addrCounter == pageNext(lastAddr))
		else $error("Counter not past last byte");

endmodule

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync (
	// System
	input  wire logic clk,
	input  wire logic rst_n,
	// Raw pins
	input  wire logic sclPin,
	input  wire logic sdaPin,
	input  wire logic wiPin,
	// Synchronised levels and edges
	output logic      scl,
	output logic      sda,
	output logic      wi,
	output logic      sclRise,
	output logic      sclFall,
	output logic      sdaRise,
	output logic      sdaFall
);

	logic [2:0] meta;                                   // First stage, read only by second
	logic [2:0] sync;                                   // Second stage
	logic [1:0] prev;                                   // Previous scl and sda

	// ==========================================================
	// Two flip-flop synchronisers, idle bus reads high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= 3'h3;
			sync <= 3'h3;
		end else begin
			meta <= {wiPin, sdaPin, sclPin};
			sync <= meta;
		end
	end

	// ==========================================================
	// Edge detection on synchronised levels
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev <= 2'h3;
		end else begin
			prev <= sync[1:0];
		end
	end

	assign scl     = sync[0];
	assign sda     = sync[1];
	assign wi      = sync[2];
	assign sclRise = sync[0] & ~prev[0];
	assign sclFall = ~sync[0] & prev[0];
	assign sdaRise = sync[1] & ~prev[1];
	assign sdaFall = ~sync[1] & prev[1];

endmodule

// ---- hdl/wr_fifo.sv ----
`timescale 1ns/1ns
module wr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// System
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Drain side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];                      // Flip-flop storage
	logic [AW-1:0]    wrPtr;                            // Next slot to fill
	logic [AW-1:0]    rdPtr;                            // Oldest slot
	logic [AW:0]      count;                            // Words held
	logic             push;
	logic             pop;

	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;
	assign inReady  = count != (AW+1)'(DEPTH);
	assign outValid = count != '0;
	assign outData  = mem[rdPtr];

	// ==========================================================
	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// ==========================================================
	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// ---- test/i2c_master_model.sv ----
`timescale 1ns/1ns
// ====================
// Bus master: owns the clock, data is open drain
module i2c_master_model (
	// Bus wires
	output logic      sclOut,
	output logic      sdaOut,
	input  wire logic sdaBus
);
	// Idle bus: both lines released high
	initial begin
		sclOut = 1'b1;
		sdaOut = 1'b1;
	end
	// Start, also usable as repeated start
	task automatic startCond();
		sdaOut = 1'b1;
		#8 sclOut = 1'b1;
		#8 sdaOut = 1'b0;
		#8 sclOut = 1'b0;
		#8;
	endtask
	// Stop leaves the clock standing high
	task automatic stopCond();
		sdaOut = 1'b0;
		#8 sclOut = 1'b1;
		#8 sdaOut = 1'b1;
		#16;
	endtask
	// Byte MSB first, data moves only while clock low, ack late in pulse nine
	task automatic sendByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sdaOut = b[i];
			#8 sclOut = 1'b1;
			#16 sclOut = 1'b0;
			#8;
		end
		sdaOut = 1'b1;
		#8 sclOut = 1'b1;
		#14 ack = !sdaBus;
		#2 sclOut = 1'b0;
		#16;
	endtask
endmodule

// ---- test/tb_i2c_eeprom_slave_write_path.sv ----
`timescale 1ns/1ns
module tb_i2c_eeprom_slave_write_path;
	// ====================
	// Signals
	localparam int WCYC = 200;                    // Shortened write cycle
	logic                    clk, rst_n, sclPin, mSda, wip, stageReady, a;
	logic [7:0]              addressConfig, protectionConfig, sel, bnd;
	logic [2:0]              ce;
	logic                    sdaOut, sdaOe, stageValid, commitWrite, discardWrite, writeBusy;
	logic [15:0]             addrCounter;
	eeprom_wr_pkg::wr_item_s stageItem;
	eeprom_wr_pkg::wr_item_s expQ[$];             // Bytes due at the stage port
	int                      err_total, compares, commits, discards, unused;
	wire                     sdaBus = mSda & (sdaOe ? sdaOut : 1'b1); // Pulled-up wire

	eeprom_write_slave #(.WRITE_CYCLES(WCYC)) u_eeprom_write_slave (.clk(clk), .rst_n(rst_n),
		.sclPin(sclPin), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeInhibitPin(wip),
		.addressConfig(addressConfig), .protectionConfig(protectionConfig), .stageValid(stageValid),
		.stageItem(stageItem), .stageReady(stageReady), .commitWrite(commitWrite),
		.discardWrite(discardWrite), .writeBusy(writeBusy), .addrCounter(addrCounter));
	i2c_master_model u_i2c_master_model (.sclOut(sclPin), .sdaOut(mSda), .sdaBus(sdaBus));

	// 250 MHz clock
	always #2 clk = ~clk;

	// Count commits, compare each popped byte in order
	always @(posedge clk) begin
		commits += (commitWrite === 1'b1);
		discards += (discardWrite === 1'b1);
		if (stageValid === 1'b1 && stageReady) begin
			if (expQ.size() == 0) check(1, 0);
			else check(stageItem, expQ.pop_front());
		end
	end

	// ====================
	// Tasks
	task automatic check(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Target space a write lands in, from type nibble and first address byte
	function automatic eeprom_wr_pkg::target_e tgtOf(input logic [7:0] s, hi);
		if (s[7:4] == eeprom_wr_pkg::SEL_MEMORY) return eeprom_wr_pkg::TGT_MEMORY;
		if (hi[7:5] == eeprom_wr_pkg::FEAT_ADDRCFG) return eeprom_wr_pkg::TGT_ADDRCFG;
		return eeprom_wr_pkg::TGT_IDPAGE;
	endfunction

	// Wait out a write cycle, bounded
	task automatic idle();
		for (int k = 0; k < 400 && writeBusy !== 1'b0; k++) @(negedge clk);
	endtask

	// Select, two address bytes, n data bytes, stop
	task automatic wr(input logic [7:0] s, hi, lo, input int n, input logic selAck, dAck);
		logic ok, all, mem, e;
		logic [7:0] d;
		eeprom_wr_pkg::target_e t;
		int c0, d0;
		all = dAck;
		mem = (s[7:4] == eeprom_wr_pkg::SEL_MEMORY);
		t = tgtOf(s, hi);
		c0 = commits;
		d0 = discards;
		u_i2c_master_model.startCond();
		u_i2c_master_model.sendByte(s, ok);
		check(ok, selAck);
		if (selAck) begin
			u_i2c_master_model.sendByte(hi, ok);
			check(ok, 1'b1);
			u_i2c_master_model.sendByte(lo, ok);
			check(ok, 1'b1);
		end
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			e = dAck && (stageReady || i < eeprom_wr_pkg::FIFO_DEPTH);
			// Queue the item before the byte: it pops before the ack comes back
			if (e) expQ.push_back(eeprom_wr_pkg::wr_item_s'({t, hi, (t != eeprom_wr_pkg::TGT_IDPAGE) & lo[7],
				lo[6:0] + 7'(i), d}));
			u_i2c_master_model.sendByte(d, ok);
			check(ok, e);
			all = all && ok === 1'b1;
		end
		// Stalled consumer: drain the full buffer before ending
		if (!stageReady) begin
			@(negedge clk) stageReady = 1'b1;
			repeat (20) @(negedge clk);
		end
		u_i2c_master_model.stopCond();
		repeat (10) @(negedge clk);
		check(expQ.size(), 0);
		expQ.delete();
		if (dAck && !all) idle();
		if (dAck && !all) return;
		all = all && n > 0 && selAck;
		check(discards - d0, 2 - int'(all));
		check(commits - c0, int'(all));
		check(writeBusy, all);
		if (!all) return;
		// Busy: even our own select gets no answer
		u_i2c_master_model.startCond();
		u_i2c_master_model.sendByte(s, ok);
		check(ok, 1'b0);
		u_i2c_master_model.stopCond();
		idle();
		if (mem && lo[6:0] + n < 128) check(addrCounter, {hi, lo} + 16'(n));
	endtask

	task automatic tally_and_finish();
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ====================
	// Main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		wip = 1'b0;
		stageReady = 1'b1;
		addressConfig = 8'h00;
		protectionConfig = 8'h00;
		unused = $urandom(97);
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Read selects against random chip enable settings
		for (int k = 0; k < 8; k++) begin
			ce = 3'($urandom);
			@(negedge clk) addressConfig = {4'h0, ce, 1'b0};
			u_i2c_master_model.startCond();
			u_i2c_master_model.sendByte({eeprom_wr_pkg::SEL_MEMORY, 3'(k), 1'b1}, a);
			check(a, 3'(k) == ce);
			u_i2c_master_model.stopCond();
		end
		sel = {eeprom_wr_pkg::SEL_MEMORY, ce, 1'b0};
		wr({4'h5, ce, 1'b0}, 8'h00, 8'h00, 0, 1'b0, 1'b0);
		wr(sel, 8'($urandom), 8'($urandom), 1, 1'b1, 1'b1);
		wr(sel, 8'h12, 8'hfe, 3, 1'b1, 1'b1);
		wr(sel, 8'h34, 8'h56, 0, 1'b1, 1'b0);
		wr({eeprom_wr_pkg::SEL_FEATURE, ce, 1'b0}, 8'h00, 8'h85, 2, 1'b1, 1'b1);
		wr({eeprom_wr_pkg::SEL_FEATURE, ce, 1'b0}, 8'hc0, 8'h85, 1, 1'b1, 1'b1);
		wr({eeprom_wr_pkg::SEL_FEATURE, ce, 1'b0}, 8'he0, 8'h00, 1, 1'b1, 1'b0);
		@(negedge clk) stageReady = 1'b0;
		wr(sel, 8'h40, 8'hf8, 17, 1'b1, 1'b1);
		// Each protected size: a random byte in the lowest protected 256-byte block, last byte below it (wraps to ffff for whole array)
		for (int s = 0; s < 4; s++) begin
			@(negedge clk) protectionConfig = {4'h0, 1'b1, 2'(s), 1'b0};
			bnd = 8'hc0 - 8'(s * 64);
			wr(sel, bnd, 8'($urandom), 1, 1'b1, 1'b0);
			wr(sel, bnd - 8'h01, 8'hff, 1, 1'b1, s != 3);
		end
		@(negedge clk) protectionConfig = 8'h00;
		wip = 1'b1;
		wr(sel, 8'($urandom), 8'($urandom), 1, 1'b1, 1'b0);
		tally_and_finish();
	end

	// Watchdog well beyond the expected run
	initial begin
		#300000;
		err_total++;
		tally_and_finish();
	end
endmodule
